// >>> logic/gen_ctrl_pkg.sv
// Package with offsets, field positions, reset values and timing counts.
package gen_ctrl_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // Register offsets.
  localparam logic [4:0] GC1_OFFSET = 5'h00;
  localparam logic [4:0] GC2_OFFSET = 5'h01;
  localparam logic [4:0] CH1_DLY_OFFSET = 5'h0e;
  localparam logic [4:0] CH2_DLY_OFFSET = 5'h0f;
  localparam logic [4:0] CH3_DLY_OFFSET = 5'h10;

  // Reset values.
  localparam logic [15:0] GC1_RESET = 16'h0026;
  localparam logic [15:0] GC2_RESET = 16'h4180;
  localparam logic [15:0] DLY_RESET = 16'h0a0a;

  // Writable bits of the first control register; bits 6 and 4 stay zero.
  localparam logic [15:0] GC1_WMASK = 16'hffaf;

  // Field positions in the first control register.
  localparam int unsigned SENSE2_DIR_BIT = 15;
  localparam int unsigned SENSE2_GAIN_HI = 14;
  localparam int unsigned SENSE2_GAIN_LO = 13;
  localparam int unsigned SENSE1_DIR_BIT = 12;
  localparam int unsigned SENSE1_GAIN_HI = 11;
  localparam int unsigned SENSE1_GAIN_LO = 10;
  localparam int unsigned BANK_BIT = 9;
  localparam int unsigned OVERVOLT_BIT = 8;
  localparam int unsigned UNLOCK_BIT = 7;
  localparam int unsigned RSVD_HI_BIT = 6;
  localparam int unsigned MOD_BIT = 5;
  localparam int unsigned RSVD_LO_BIT = 4;
  localparam int unsigned STEP_BIT = 3;
  localparam int unsigned OC_EN_BIT = 2;
  localparam int unsigned WD_PER_BIT = 1;
  localparam int unsigned WD_TOGGLE_BIT = 0;

  // Field position in the second control register.
  localparam int unsigned WD_DIS_BIT = 9;

  // Watchdog timing.
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned WD_SHORT_MS = 50;
  localparam int unsigned WD_LONG_MS = 200;
  localparam int unsigned WD_SHORT_CYCLES = WD_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_LONG_CYCLES = WD_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_CNT_W = 23;

endpackage

// >>> logic/general_control_regs.sv
// General control register, watchdog control and channel delay registers.
`timescale 1ns/1ps

module general_control_regs #(
  parameter int unsigned WD_SHORT_LIMIT = gen_ctrl_pkg::WD_SHORT_CYCLES,
  parameter int unsigned WD_LONG_LIMIT = gen_ctrl_pkg::WD_LONG_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Decoded serial frame
  input wire logic frame_valid_i,
  input wire logic frame_write_i,
  input wire logic [gen_ctrl_pkg::ADDR_W-1:0] frame_addr_i,
  input wire logic [gen_ctrl_pkg::DATA_W-1:0] frame_wdata_i,
  // Read answer
  output logic [gen_ctrl_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  // Control fields
  output logic sense_two_direction_o,
  output logic [1:0] sense_two_gain_o,
  output logic sense_one_direction_o,
  output logic [1:0] sense_one_gain_o,
  output logic bank_select_o,
  output logic supply_overvoltage_level_o,
  output logic spread_modulation_enable_o,
  output logic adapt_step_size_o,
  output logic overcurrent_shutdown_enable_o,
  output logic watchdog_period_select_o,
  output logic watchdog_disable_o,
  output logic fail_safe_o,
  // Channel delays
  output logic [gen_ctrl_pkg::DATA_W-1:0] channel_one_edge_delays_o,
  output logic [gen_ctrl_pkg::DATA_W-1:0] channel_two_edge_delays_o,
  output logic [gen_ctrl_pkg::DATA_W-1:0] channel_three_edge_delays_o
);
  import gen_ctrl_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [15:0] gc1_q;
  logic [15:0] gc1_d;
  logic [15:0] gc2_q;
  logic [15:0] gc2_d;
  logic [15:0] dly1_q;
  logic [15:0] dly2_q;
  logic [15:0] dly3_q;
  logic unlock_prev_q;
  logic fail_safe_q;
  logic fail_safe_d;
  logic [WD_CNT_W-1:0] wd_cnt_q;
  logic [WD_CNT_W-1:0] wd_cnt_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;

  // A pure compare, since a continuous assignment wakes only on its arguments.
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction

  // The released reset is the second synchroniser stage; nothing taps the first.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Address decode.
  wire gc1_hit = frame_valid_i && hit(frame_addr_i, GC1_OFFSET);
  wire gc2_hit = frame_valid_i && hit(frame_addr_i, GC2_OFFSET);
  wire dly1_hit = frame_valid_i && hit(frame_addr_i, CH1_DLY_OFFSET);
  wire dly2_hit = frame_valid_i && hit(frame_addr_i, CH2_DLY_OFFSET);
  wire dly3_hit = frame_valid_i && hit(frame_addr_i, CH3_DLY_OFFSET);
  wire gc1_wr = gc1_hit && frame_write_i;
  wire gc2_wr = gc2_hit && frame_write_i;

  // Reserved bits are masked off so they never store a one.
  assign gc1_d = gc1_wr ? (frame_wdata_i & GC1_WMASK) : gc1_q;

  // An unchanged toggle bit on a control write is a watchdog violation.
  wire toggle_stale = gc1_wr &&
    (frame_wdata_i[WD_TOGGLE_BIT] == gc1_q[WD_TOGGLE_BIT]);

  // Unlock only counts when the frame just before this one set it.
  wire dis_set_req = gc2_wr && frame_wdata_i[WD_DIS_BIT];
  wire dis_allowed = unlock_prev_q || gc2_q[WD_DIS_BIT];
  wire dis_next = gc2_wr ? (dis_set_req && dis_allowed) : gc2_q[WD_DIS_BIT];
  assign gc2_d = gc2_wr ?
    {frame_wdata_i[15:10], dis_next, frame_wdata_i[8:0]} : gc2_q;

  // Any frame consumes the unlock, so it reaches only the next frame.
  wire unlock_next = frame_valid_i ?
    (gc1_wr && frame_wdata_i[UNLOCK_BIT]) : unlock_prev_q;

  // Watchdog limit follows the current period select.
  wire [WD_CNT_W-1:0] wd_limit = gc1_q[WD_PER_BIT] ?
    WD_CNT_W'(WD_LONG_LIMIT - 1) : WD_CNT_W'(WD_SHORT_LIMIT - 1);
  wire wd_running = !gc2_q[WD_DIS_BIT] && !fail_safe_q;
  wire wd_kick = gc1_wr && !toggle_stale;
  wire wd_expire = wd_running && !wd_kick && (wd_cnt_q >= wd_limit);

  // Restarting on a good toggle relies on the host keeping the period.
  assign wd_cnt_d = (!wd_running || wd_kick) ? '0 :
    (wd_expire ? wd_cnt_q : wd_cnt_q + 1'b1);

  // Fail-safe is sticky; only a reset leaves it.
  assign fail_safe_d = fail_safe_q || toggle_stale || wd_expire;

  // Read mux; unmapped offsets answer zero.
  always_comb begin
    if (gc1_hit) begin
      rdata_d = gc1_q;
    end else if (gc2_hit) begin
      rdata_d = gc2_q;
    end else if (dly1_hit) begin
      rdata_d = dly1_q;
    end else if (dly2_hit) begin
      rdata_d = dly2_q;
    end else if (dly3_hit) begin
      rdata_d = dly3_q;
    end else begin
      rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gc1_q <= GC1_RESET;
      gc2_q <= GC2_RESET;
      unlock_prev_q <= 1'b0;
      fail_safe_q <= 1'b0;
      wd_cnt_q <= '0;
    end else begin
      gc1_q <= gc1_d;
      gc2_q <= gc2_d;
      unlock_prev_q <= unlock_next;
      fail_safe_q <= fail_safe_d;
      wd_cnt_q <= wd_cnt_d;
    end
  end

  // Delay registers ignore the bank select entirely.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dly1_q <= DLY_RESET;
      dly2_q <= DLY_RESET;
      dly3_q <= DLY_RESET;
    end else begin
      if (dly1_hit && frame_write_i) begin
        dly1_q <= frame_wdata_i;
      end
      if (dly2_hit && frame_write_i) begin
        dly2_q <= frame_wdata_i;
      end
      if (dly3_hit && frame_write_i) begin
        dly3_q <= frame_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= (frame_valid_i && !frame_write_i) ? rdata_d : rdata_q;
      rvalid_q <= frame_valid_i && !frame_write_i;
    end
  end

  // Outputs are slices of flip-flops.
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign sense_two_direction_o = gc1_q[SENSE2_DIR_BIT];
  assign sense_two_gain_o = gc1_q[SENSE2_GAIN_HI:SENSE2_GAIN_LO];
  assign sense_one_direction_o = gc1_q[SENSE1_DIR_BIT];
  assign sense_one_gain_o = gc1_q[SENSE1_GAIN_HI:SENSE1_GAIN_LO];
  assign bank_select_o = gc1_q[BANK_BIT];
  assign supply_overvoltage_level_o = gc1_q[OVERVOLT_BIT];
  assign spread_modulation_enable_o = gc1_q[MOD_BIT];
  assign adapt_step_size_o = gc1_q[STEP_BIT];
  assign overcurrent_shutdown_enable_o = gc1_q[OC_EN_BIT];
  assign watchdog_period_select_o = gc1_q[WD_PER_BIT];
  assign watchdog_disable_o = gc2_q[WD_DIS_BIT];
  assign fail_safe_o = fail_safe_q;
  assign channel_one_edge_delays_o = dly1_q;
  assign channel_two_edge_delays_o = dly2_q;
  assign channel_three_edge_delays_o = dly3_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  chk_reserved_bits_zero: assert property (
    !gc1_q[RSVD_HI_BIT] && !gc1_q[RSVD_LO_BIT])
    else $error("reserved control bit stored a one");

  chk_reserved_read_zero: assert property (
    gc1_hit && !frame_write_i |=> rvalid_o && !rdata_o[RSVD_HI_BIT])
    else $error("reserved bit read back as one");

  chk_stale_toggle_fails: assert property (
    gc1_wr && frame_wdata_i[0] == gc1_q[0] |=> fail_safe_o)
    else $error("stale toggle did not enter fail-safe");

  chk_good_toggle_safe: assert property (
    gc1_wr && frame_wdata_i[0] != gc1_q[0] && !fail_safe_q |=> !fail_safe_o)
    else $error("good toggle entered fail-safe");

  chk_disable_locked: assert property (
    gc2_wr && frame_wdata_i[WD_DIS_BIT] && !watchdog_disable_o
    && !unlock_prev_q |=> !watchdog_disable_o)
    else $error("watchdog disabled without unlock");

  // The host may leave one idle cycle between the unlock and the disable.
  chk_disable_unlocked: assert property (
    (gc1_wr && frame_wdata_i[UNLOCK_BIT] ##1 gc2_wr
    && frame_wdata_i[WD_DIS_BIT]) or (gc1_wr && frame_wdata_i[UNLOCK_BIT]
    ##1 !frame_valid_i ##1 gc2_wr && frame_wdata_i[WD_DIS_BIT])
    |=> watchdog_disable_o)
    else $error("unlocked disable did not take effect");

  chk_unlock_consumed: assert property (
    frame_valid_i && !gc1_wr |=> !unlock_prev_q)
    else $error("unlock survived a later frame");

  chk_sense_two_fields: assert property (
    gc1_wr |=> sense_two_direction_o == $past(frame_wdata_i[SENSE2_DIR_BIT])
    && sense_two_gain_o == $past(frame_wdata_i[SENSE2_GAIN_HI:SENSE2_GAIN_LO]))
    else $error("second amplifier fields did not follow write");

  chk_sense_one_fields: assert property (
    gc1_wr |=> sense_one_direction_o == $past(frame_wdata_i[SENSE1_DIR_BIT])
    && sense_one_gain_o == $past(frame_wdata_i[SENSE1_GAIN_HI:SENSE1_GAIN_LO]))
    else $error("first amplifier fields did not follow write");

  chk_modulation_follows: assert property (
    gc1_wr |=> spread_modulation_enable_o == $past(frame_wdata_i[MOD_BIT]))
    else $error("modulation enable did not follow write");

  chk_step_follows: assert property (
    gc1_wr |=> adapt_step_size_o == $past(frame_wdata_i[STEP_BIT]))
    else $error("adaptation step did not follow write");

  chk_overcurrent_follows: assert property (
    gc1_wr |=> overcurrent_shutdown_enable_o == $past(frame_wdata_i[OC_EN_BIT]))
    else $error("overcurrent enable did not follow write");

  chk_period_follows: assert property (
    gc1_wr |=> watchdog_period_select_o == $past(frame_wdata_i[WD_PER_BIT]))
    else $error("watchdog period did not follow write");

  chk_delay_other_writes: assert property (
    (dly1_hit || dly3_hit) && frame_write_i |=> $past(frame_wdata_i) ==
    (($past(dly1_hit)) ? channel_one_edge_delays_o : channel_three_edge_delays_o))
    else $error("delay register write lost");

  chk_disable_clear: assert property (
    gc2_wr && !frame_wdata_i[WD_DIS_BIT] |=> !watchdog_disable_o)
    else $error("watchdog disable did not clear at once");

  chk_delay_bank_free: assert property (
    dly2_hit && frame_write_i |=>
    channel_two_edge_delays_o == $past(frame_wdata_i))
    else $error("delay register write lost");

  chk_bank_follows: assert property (
    gc1_wr |=> bank_select_o == $past(frame_wdata_i[BANK_BIT]))
    else $error("bank select did not follow write");

  chk_reset_value: assert property (
    $rose(rst_n) |-> gc1_q == GC1_RESET && !fail_safe_q)
    else $error("control register not at reset value");

  chk_expire_fails: assert property (
    wd_expire |=> fail_safe_o && $stable(gc2_q[WD_DIS_BIT]))
    else $error("watchdog expiry missed fail-safe");

  cov_good_toggle: cover property (gc1_wr && !toggle_stale);
  cov_unlock_disable: cover property (gc1_wr ##2 gc2_wr && dis_next);
  cov_timeout: cover property (wd_expire);
  cov_delay_read: cover property (dly3_hit && !frame_write_i);

endmodule

// >>> test/frame_host.sv
// Host model that issues decoded register frames to the block.
`timescale 1ns/1ps

module frame_host (
  // Clock
  input wire logic clk_i,
  // Frame outputs
  output logic valid_o = 1'b0,
  output logic write_o = 1'b0,
  output logic [4:0] addr_o = 5'h00,
  output logic [15:0] wdata_o = 16'h0000
);
  logic tog_q = 1'b0;

  // Idle lines carry the inverse of the last frame, so stale data never
  // passes for a fresh request.
  task automatic frame(input logic wr, input logic [4:0] a,
                       input logic [15:0] d);
    @(negedge clk_i);
    valid_o = 1'b1;
    write_o = wr;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    valid_o = 1'b0;
    write_o = ~wr;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // A stale write is only sent when a scenario asks for one.
  task automatic wr_gc1(input logic [15:0] d, input logic stale);
    if (!stale) begin
      tog_q = ~tog_q;
    end
    frame(1'b1, gen_ctrl_pkg::GC1_OFFSET, {d[15:1], tog_q});
  endtask
endmodule

// >>> test/general_control_watchdog_regs_tb.sv
// Self-checking bench for the general control register block.
`timescale 1ns/1ps

module general_control_watchdog_regs_tb;
  import gen_ctrl_pkg::*;

  localparam int SHORT_LIM = 400;
  localparam int LONG_LIM = 1000;

  typedef struct packed {
    logic [4:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;

  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic fv, fw, rv, s2d, s1d, bank, ov, modu, step, oc, per, wdd, fs;
  logic [4:0] fa;
  logic [15:0] fd, rd_q, d1, d2, d3;
  logic [1:0] s2g, s1g;
  wire logic [15:0] fld = {s2d, s2g, s1d, s1g, bank, ov, 2'b00, modu,
                           1'b0, step, oc, per, 1'b0};
  int error_cnt = 0;
  int n_tests = 0;
  row_t rows [9] = '{
    '{GC1_OFFSET, 16'hffff, 16'hffaf},
    '{CH1_DLY_OFFSET, 16'h1234, 16'h1234},
    '{CH2_DLY_OFFSET, 16'h5678, 16'h5678},
    '{CH3_DLY_OFFSET, 16'h9abc, 16'h9abc},
    '{5'h11, 16'hffff, 16'h0000},
    '{GC1_OFFSET, 16'h2c0a, 16'h2c0a},
    '{GC1_OFFSET, 16'h4451, 16'h4401},
    '{5'h1f, 16'h5555, 16'h0000},
    '{GC1_OFFSET, 16'h0000, 16'h0000}};

  always #20 clk_i = ~clk_i;

  frame_host host (.clk_i(clk_i), .valid_o(fv), .write_o(fw), .addr_o(fa),
    .wdata_o(fd));

  general_control_regs #(.WD_SHORT_LIMIT(SHORT_LIM),
    .WD_LONG_LIMIT(LONG_LIM)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .frame_valid_i(fv), .frame_write_i(fw), .frame_addr_i(fa),
    .frame_wdata_i(fd), .rdata_o(rd_q), .rvalid_o(rv),
    .sense_two_direction_o(s2d), .sense_two_gain_o(s2g),
    .sense_one_direction_o(s1d), .sense_one_gain_o(s1g),
    .bank_select_o(bank), .supply_overvoltage_level_o(ov),
    .spread_modulation_enable_o(modu), .adapt_step_size_o(step),
    .overcurrent_shutdown_enable_o(oc), .watchdog_period_select_o(per),
    .watchdog_disable_o(wdd), .fail_safe_o(fs),
    .channel_one_edge_delays_o(d1), .channel_two_edge_delays_o(d2),
    .channel_three_edge_delays_o(d3));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    host.frame(1'b0, a, 16'h0000);
    chk("rvalid", {15'h0000, rv}, 16'h0001);
    chk("rdata", rd_q, e);
  endtask

  // The host forgets its toggle history along with the device.
  task automatic do_reset();
    @(negedge clk_i);
    rstn_i = 1'b0;
    host.tog_q = 1'b0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic wd_time(input int lim);
    int n;
    n = 0;
    while (fs !== 1'b1 && n < lim + 10) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("timeout", 16'(n >= lim - 1 && n <= lim + 1), 16'h0001);
    if (n >= lim + 10) begin
      end_of_test();
    end
  endtask

  initial begin
    repeat (5) @(negedge clk_i);
    do_reset();
    rd(GC1_OFFSET, GC1_RESET);
    chk("fields", fld, 16'h0026);
    chk("fail_safe", {15'h0000, fs}, 16'h0000);
    rd(CH1_DLY_OFFSET, DLY_RESET);
    rd(CH2_DLY_OFFSET, DLY_RESET);
    rd(CH3_DLY_OFFSET, DLY_RESET);
    foreach (rows[i]) begin
      if (rows[i].a == GC1_OFFSET) begin
        host.wr_gc1(rows[i].d, 1'b0);
      end else begin
        host.frame(1'b1, rows[i].a, rows[i].d);
      end
      rd(rows[i].a, rows[i].e);
      if (rows[i].a == GC1_OFFSET) begin
        chk("fields", fld, rows[i].e & 16'hff2e);
      end
      chk("fail_safe", {15'h0000, fs}, 16'h0000);
    end
    chk("delay1", d1, 16'h1234);
    chk("delay2", d2, 16'h5678);
    chk("delay3", d3, 16'h9abc);
    // Setting the disable bit without the unlock frame must not stick.
    host.frame(1'b1, GC2_OFFSET, 16'h4380);
    rd(GC2_OFFSET, GC2_RESET);
    // An unlock spent on a read frame must not open the disable bit.
    host.wr_gc1(16'h0080, 1'b0);
    rd(GC2_OFFSET, GC2_RESET);
    host.frame(1'b1, GC2_OFFSET, 16'h4380);
    rd(GC2_OFFSET, GC2_RESET);
    host.wr_gc1(16'h0080, 1'b0);
    host.frame(1'b1, GC2_OFFSET, 16'h4380);
    rd(GC2_OFFSET, 16'h4380);
    chk("wd_disable", {15'h0000, wdd}, 16'h0001);
    repeat (LONG_LIM + 100) @(negedge clk_i);
    chk("fail_safe", {15'h0000, fs}, 16'h0000);
    host.frame(1'b1, GC2_OFFSET, GC2_RESET);
    chk("wd_disable", {15'h0000, wdd}, 16'h0000);
    host.wr_gc1(16'h0000, 1'b0);
    wd_time(SHORT_LIM);
    do_reset();
    chk("fail_safe", {15'h0000, fs}, 16'h0000);
    host.wr_gc1(16'h0002, 1'b0);
    wd_time(LONG_LIM);
    do_reset();
    host.wr_gc1(16'h0026, 1'b1);
    chk("fail_safe", {15'h0000, fs}, 16'h0001);
    rd(GC1_OFFSET, 16'h0026);
    end_of_test();
  end
endmodule
